// File: hdl/pllcg_defs.vh
// Purpose: Constants for the clock generator control block
// Assumes: 32-bit AXI4-Lite register bus, byte addressing
// Notes:   Register index times four gives the byte address
`ifndef PLLCG_DEFS_VH
`define PLLCG_DEFS_VH

// Register indices and byte addresses
`define PLLCG_IDX_CTRL     8'h1c
`define PLLCG_IDX_BW       8'h1d
`define PLLCG_IDX_MUL      8'h1e
`define PLLCG_ADDR_CTRL    8'h70
`define PLLCG_ADDR_BW      8'h74
`define PLLCG_ADDR_MUL     8'h78

// Control register fields
`define PLLCG_CTRL_IRQEN   7
`define PLLCG_CTRL_LKFLG   6
`define PLLCG_CTRL_PON     5
`define PLLCG_CTRL_BSEL    4
`define PLLCG_CTRL_ONES    4'hf

// Bandwidth register fields
`define PLLCG_BW_AUTO      7
`define PLLCG_BW_LOCK      6
`define PLLCG_BW_TRK       5

// Multiplier register fields
`define PLLCG_MUL_N_HI     7
`define PLLCG_MUL_N_LO     4
`define PLLCG_MUL_L_HI     3
`define PLLCG_MUL_L_LO     0

// Reset values
`define PLLCG_RST_PON      1'b1
`define PLLCG_RST_MUL      8'h66

// Nominal center-of-range frequency in Hz
`define PLLCG_FNOM_HZ      23'd4915200

// Lock detector window in reference periods, tolerances in feedback edges
`define PLLCG_WIN_REFS     8'd64
`define PLLCG_TOL_TRK      8'd2
`define PLLCG_TOL_UNT      8'd4
`define PLLCG_TOL_LOCK     8'd1
`define PLLCG_TOL_UNL      8'd3

// AXI responses
`define PLLCG_RESP_OKAY    2'b00
`define PLLCG_RESP_SLVERR  2'b10

`endif

// File: hdl/pllcg_top.v
// Purpose: Digital control of a crystal-referenced phase-locked clock generator
// Assumes: Crystal and VCO clocks arrive as levels sampled on clock_in
// Notes:   Analog VCO and loop filter sit outside; this drives their controls
//
// Overview of operation
// - Oscillator runs only while system enable high
// - Reference is buffered crystal clock, undivided
// - Feedback clock is VCO clock divided by N
// - Phase detector emits up/down correction pulses
// - Lock detector compares feedback and reference frequencies
// - VCO center frequency is L times nominal
// - Acquisition mode shows tracking bit clear
// - Tracking mode when not acquiring or bit set
// - Automatic mode lets detector switch filter mode
// - Automatic mode makes tracking bit read-only
// - Tracking set within tight, cleared outside wide
// - Lock flag read-only with lock/unlock hysteresis
// - Lock toggles raise interrupt when enabled, automatic
// - Manual mode tracking bit is writable control
// - Manual mode disables lock flag and interrupts
// - Upper multiplier nibble holds divide factor N
// - Lower multiplier nibble holds range factor L
// - Base clock is half the selected source clock
// - Divide factor zero acts as one
// - Range factor zero disables loop, forces crystal
// - Base clock select chooses VCO or crystal
// - Multiplier register read-only while powered on
`timescale 1ns/1ps
`include "pllcg_defs.vh"
`default_nettype none

module pllcg_top (
  input  wire        clock_in,
  input  wire        rst_n_in,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // Clock generator signals
  input  wire        osc_enable_from_sysmod_in,
  input  wire        crystal_clock_in,
  input  wire        vco_clock_in,
  output reg         osc_run_out,
  output reg         pll_reference_clock_out,
  output reg         final_reference_clock_out,
  output reg         vco_feedback_clock_out,
  output reg         pump_up_out,
  output reg         pump_down_out,
  output reg         filter_tracking_out,
  output reg         pll_enable_out,
  output reg  [26:0] vco_center_hz_out,
  output reg         base_clock_out,
  output reg         lock_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg        lock_irq_enable;       // Lock interrupt enable
  reg        lock_irq_flag;         // Sticky lock-change flag
  reg        pll_power_on;          // Loop power control
  reg        base_clock_select;     // 1 selects VCO clock
  reg        auto_mode;             // Automatic bandwidth control
  reg        filter_tracking_bit;   // Manual tracking control
  reg [7:0]  multiplier_register;   // N in upper, L in lower nibble
  reg        trk_auto;              // Detector tracking decision
  reg        lock_state;            // Detector lock decision
  reg        lock_seen;             // Lock state as software sees it
  reg        trk_seen;              // Tracking state as software sees it
  reg        xclk_q;                // Previous crystal sample
  reg        vclk_q;                // Previous VCO sample
  reg [3:0]  div_cnt;               // Modulo-N counter
  reg        fb_tick;               // One-cycle feedback edge
  reg        ref_tick;              // One-cycle reference edge
  reg [7:0]  win_cnt;               // Reference periods in window
  reg [7:0]  fb_cnt;                // Feedback edges in window
  reg        aw_held;               // Write address latched
  reg        w_held;                // Write data latched
  reg [7:0]  aw_addr;               // Latched write address
  reg [7:0]  w_data;                // Latched write byte
  reg        w_lane;                // Latched lane 0 strobe
  reg [7:0]  rd_value;              // Read mux result
  reg        rd_hit;                // Read address decoded

  wire [3:0] mul_n = multiplier_register[`PLLCG_MUL_N_HI:`PLLCG_MUL_N_LO];
  wire [3:0] mul_l = multiplier_register[`PLLCG_MUL_L_HI:`PLLCG_MUL_L_LO];
  wire [3:0] n_eff = (mul_n == 4'h0) ? 4'h1 : mul_n;
  wire       l_zero = (mul_l == 4'h0);
  wire       loop_on = pll_power_on & ~l_zero & osc_run_out;
  wire       xrise = crystal_clock_in & ~xclk_q;
  wire       vrise = vco_clock_in & ~vclk_q & loop_on;
  wire       win_end = ref_tick & (win_cnt == `PLLCG_WIN_REFS - 8'h01);
  wire [7:0] fb_total = fb_cnt + {7'h00, fb_tick};
  wire [7:0] fdiff = (fb_total > `PLLCG_WIN_REFS) ? fb_total - `PLLCG_WIN_REFS
                                                  : `PLLCG_WIN_REFS - fb_total;
  wire       tracking = auto_mode ? trk_auto : filter_tracking_bit;
  wire       write_go = aw_held & w_held & ~s_axi_bvalid_out;
  wire       wr_ok = (aw_addr == `PLLCG_ADDR_CTRL) | (aw_addr == `PLLCG_ADDR_BW) |
                     (aw_addr == `PLLCG_ADDR_MUL);
  wire       wr_en = write_go & w_lane;
  wire       rd_go = s_axi_arvalid_in & s_axi_arready_out;
  wire       lock_change = lock_state ^ lock_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator gating and reference clocks
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      osc_run_out               <= 1'b0;
      xclk_q                    <= 1'b0;
      vclk_q                    <= 1'b0;
      ref_tick                  <= 1'b0;
      pll_reference_clock_out   <= 1'b0;
      final_reference_clock_out <= 1'b0;
    end
    else
    begin
      osc_run_out               <= osc_enable_from_sysmod_in;
      xclk_q                    <= crystal_clock_in;
      vclk_q                    <= vco_clock_in;
      // Reference edge only counts while the oscillator runs
      ref_tick                  <= xrise & osc_run_out;
      pll_reference_clock_out   <= crystal_clock_in & osc_run_out;
      final_reference_clock_out <= crystal_clock_in & osc_run_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulo-N feedback divider
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt                <= 4'h0;
      fb_tick                <= 1'b0;
      vco_feedback_clock_out <= 1'b0;
    end
    else
    begin
      fb_tick                <= 1'b0;
      if (!loop_on)
      begin
        div_cnt <= 4'h0;                       // Held at zero while loop is off
      end
      else if (vrise)
      begin
        if (div_cnt >= n_eff - 4'h1)
        begin
          div_cnt <= 4'h0;
          fb_tick <= 1'b1;
        end
        else
        begin
          div_cnt <= div_cnt + 4'h1;
        end
      end
      // Feedback clock is one cycle high per N VCO edges
      vco_feedback_clock_out <= fb_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector: up leads on reference, down on feedback
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pump_up_out   <= 1'b0;
      pump_down_out <= 1'b0;
    end
    else if (!loop_on || (pump_up_out && pump_down_out))
    begin
      pump_up_out   <= 1'b0;                    // Both seen ends the pulse
      pump_down_out <= 1'b0;
    end
    else
    begin
      if (ref_tick)
      begin
        pump_up_out <= 1'b1;
      end
      if (fb_tick)
      begin
        pump_down_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock detector: feedback edges per window of reference periods
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      win_cnt    <= 8'h00;
      fb_cnt     <= 8'h00;
      trk_auto   <= 1'b0;
      lock_state <= 1'b0;
    end
    else if (!loop_on)
    begin
      win_cnt    <= 8'h00;
      fb_cnt     <= 8'h00;
      trk_auto   <= 1'b0;
      lock_state <= 1'b0;
    end
    else if (win_end)
    begin
      win_cnt <= 8'h00;
      fb_cnt  <= 8'h00;
      // Tracking hysteresis
      if (fdiff <= `PLLCG_TOL_TRK)
      begin
        trk_auto <= 1'b1;
      end
      else if (fdiff > `PLLCG_TOL_UNT)
      begin
        trk_auto <= 1'b0;
      end
      // Lock hysteresis, manual mode keeps lock off
      if (!auto_mode)
      begin
        lock_state <= 1'b0;
      end
      else if (fdiff <= `PLLCG_TOL_LOCK)
      begin
        lock_state <= 1'b1;
      end
      else if (fdiff > `PLLCG_TOL_UNL)
      begin
        lock_state <= 1'b0;
      end
    end
    else
    begin
      if (ref_tick)
      begin
        win_cnt <= win_cnt + 8'h01;
      end
      if (fb_tick && fb_cnt != 8'hff)
      begin
        fb_cnt <= fb_cnt + 8'h01;
      end
      if (!auto_mode)
      begin
        lock_state <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status stage toward software and loop controls
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lock_seen           <= 1'b0;
      trk_seen            <= 1'b0;
      filter_tracking_out <= 1'b0;
      pll_enable_out      <= 1'b0;
      vco_center_hz_out   <= 27'h0000000;
      lock_irq_out        <= 1'b0;
    end
    else
    begin
      lock_seen           <= lock_state;
      trk_seen            <= tracking;
      filter_tracking_out <= tracking & loop_on;
      pll_enable_out      <= loop_on;
      vco_center_hz_out   <= {23'h000000, mul_l} * {4'h0, `PLLCG_FNOM_HZ};
      lock_irq_out        <= lock_irq_flag & lock_irq_enable & auto_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base clock: selected source divided by two
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      base_clock_out <= 1'b0;
    end
    else if (base_clock_select ? vrise : (xrise & osc_run_out))
    begin
      base_clock_out <= ~base_clock_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= 8'h00;
      w_data            <= 8'h00;
      w_lane            <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `PLLCG_RESP_OKAY;
    end
    else
    begin
      // Address and data are taken independently
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held           <= 1'b1;
        aw_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held           <= 1'b1;
        w_data           <= s_axi_wdata_in[7:0];
        w_lane           <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      // Both held: commit and answer
      if (write_go)
      begin
        aw_held           <= 1'b0;
        w_held            <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
        s_axi_bvalid_out  <= 1'b1;
        s_axi_bresp_out   <= wr_ok ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lock_irq_enable     <= 1'b0;
      lock_irq_flag       <= 1'b0;
      pll_power_on        <= `PLLCG_RST_PON;
      base_clock_select   <= 1'b0;
      auto_mode           <= 1'b0;
      filter_tracking_bit <= 1'b0;
      multiplier_register <= `PLLCG_RST_MUL;
    end
    else
    begin
      // Flag: a lock change beats a read-clear in the same cycle
      if (lock_change && auto_mode)
      begin
        lock_irq_flag <= 1'b1;
      end
      else if (!auto_mode || (rd_go && s_axi_araddr_in == `PLLCG_ADDR_CTRL))
      begin
        lock_irq_flag <= 1'b0;
      end
      if (wr_en && aw_addr == `PLLCG_ADDR_CTRL)
      begin
        lock_irq_enable <= w_data[`PLLCG_CTRL_IRQEN] & auto_mode;
        // Power and select may not change together
        if (w_data[`PLLCG_CTRL_PON] != pll_power_on)
        begin
          if (!(w_data[`PLLCG_CTRL_PON] == 1'b0 && base_clock_select) &&
              w_data[`PLLCG_CTRL_BSEL] == base_clock_select)
          begin
            pll_power_on <= w_data[`PLLCG_CTRL_PON];
          end
        end
        else
        begin
          base_clock_select <= w_data[`PLLCG_CTRL_BSEL] & pll_power_on & ~l_zero;
        end
      end
      else
      begin
        if (!auto_mode)
        begin
          lock_irq_enable <= 1'b0;
        end
        if (l_zero || !pll_power_on)
        begin
          base_clock_select <= 1'b0;
        end
      end
      if (wr_en && aw_addr == `PLLCG_ADDR_BW)
      begin
        auto_mode <= w_data[`PLLCG_BW_AUTO];
        if (!w_data[`PLLCG_BW_AUTO] && !auto_mode)
        begin
          filter_tracking_bit <= w_data[`PLLCG_BW_TRK];
        end
      end
      // Frozen while the loop is powered
      if (wr_en && aw_addr == `PLLCG_ADDR_MUL && !pll_power_on)
      begin
        multiplier_register <= w_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  always @*
  begin
    rd_value = 8'h00;
    rd_hit   = 1'b1;
    case (s_axi_araddr_in)
      `PLLCG_ADDR_CTRL:
        rd_value = {lock_irq_enable, lock_irq_flag & auto_mode, pll_power_on,
                    base_clock_select, `PLLCG_CTRL_ONES};
      `PLLCG_ADDR_BW:
        rd_value = {auto_mode, lock_seen & auto_mode, trk_seen, 5'h00};
      `PLLCG_ADDR_MUL:
        rd_value = multiplier_register;
      default:
        rd_hit = 1'b0;                          // Unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `PLLCG_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= {24'h000000, rd_value};
      s_axi_rresp_out   <= rd_hit ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: testbench/pll_clock_generator_control_tb.sv
// Purpose: Self-checking bench for the clock generator control
// Assumes: Registers reached over AXI4-Lite at 40 MHz
// Notes:   Clock sources come from the far-side model
`timescale 1ns/1ps
`include "pllcg_defs.vh"
`default_nettype none
module pll_clock_generator_control_tb;
  localparam logic [7:0] AC = `PLLCG_ADDR_CTRL;
  localparam logic [7:0] AB = `PLLCG_ADDR_BW;
  localparam logic [7:0] AM = `PLLCG_ADDR_MUL;
  localparam logic [1:0] OK = `PLLCG_RESP_OKAY;
  localparam logic [1:0] SE = `PLLCG_RESP_SLVERR;
  logic        clock_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, osc_enable_from_sysmod_in;
  logic        crystal_clock_in, vco_clock_in, osc_run_out, pll_reference_clock_out;
  logic        final_reference_clock_out, vco_feedback_clock_out, pump_up_out, pump_down_out;
  logic        filter_tracking_out, pll_enable_out, base_clock_out, lock_irq_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in, vco_half;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [26:0] vco_center_hz_out;
  int          err_total, comparisons;
  logic        base_q; // Base clock sample
  pllcg_top i_pllcg_top (.clock_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .osc_enable_from_sysmod_in, .crystal_clock_in, .vco_clock_in,
    .osc_run_out, .pll_reference_clock_out, .final_reference_clock_out, .vco_feedback_clock_out,
    .pump_up_out, .pump_down_out, .filter_tracking_out, .pll_enable_out, .vco_center_hz_out,
    .base_clock_out, .lock_irq_out);
  pllcg_far_model i_pllcg_far_model (.clock_in, .rst_n_in,
    .osc_enable_in(osc_enable_from_sysmod_in), .vco_half_in(vco_half),
    .crystal_clock_out(crystal_clock_in), .vco_clock_out(vco_clock_in));
  ////////////////////////////////////////////////////////////////
  // Clock source
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////
  // Compare, verdict and bounded wait helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clock_in);
    n++;
    if (n > 8000)
    begin
      chk(n, 0, "wait bound");
      report_and_stop;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Bus cycles: write offers both channels, read waits for answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    bit ta, tw;
    n = 0;
    ta = 0;
    tw = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      tick(n);
      if (!ta && s_axi_awready_out)
      begin
        s_axi_awvalid_in <= 1'b0;
        ta = 1;
      end
      if (!tw && s_axi_wready_out)
      begin
        s_axi_wvalid_in <= 1'b0;
        tw = 1;
      end
    end while (!(ta && tw));
    do tick(n); while (!s_axi_bvalid_out);
    chk(s_axi_bresp_out, er, "bresp");
    s_axi_bready_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do tick(n); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do tick(n); while (!s_axi_rvalid_out);
    chk(s_axi_rdata_out, {24'h0, ed}, "rdata");
    chk(s_axi_rresp_out, er, "rresp");
    s_axi_rready_in <= 1'b0;
    @(posedge clock_in);
  endtask
  // Cycles between two feedback pulses
  task automatic fb_gap(input int exp);
    int n, g;
    n = 0;
    g = 0;
    do tick(n); while (!vco_feedback_clock_out);
    do
    begin
      tick(n);
      g++;
    end while (!vco_feedback_clock_out);
    chk(g, exp, "feedback gap");
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    do tick(n); while (lock_irq_out !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    err_total = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    vco_half = 4'h2;
    osc_enable_from_sysmod_in = 1'b1;
    s_axi_awaddr_in = 8'h00;
    s_axi_araddr_in = 8'h00;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'h1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    rd(AC, 8'h2f, OK);
    rd(AB, 8'h00, OK);
    rd(AM, 8'h66, OK);
    chk(vco_center_hz_out, `PLLCG_FNOM_HZ * 32'd6, "center");
    rd(8'h7c, 8'h00, SE);
    wr(8'h00, 8'hff, SE);
    wr(AM, 8'h34, OK);
    rd(AM, 8'h66, OK);
    wr(AC, 8'h00, OK);
    rd(AC, 8'h0f, OK);
    wr(AM, 8'h34, OK);
    rd(AM, 8'h34, OK);
    wr(AC, 8'h20, OK);
    fb_gap(12);
    chk(vco_center_hz_out, `PLLCG_FNOM_HZ * 32'd4, "center");
    wr(AC, 8'h00, OK);
    wr(AM, 8'h04, OK);
    wr(AC, 8'h20, OK);
    fb_gap(4);
    wr(AC, 8'h00, OK);
    wr(AM, 8'h40, OK);
    wr(AC, 8'h20, OK);
    wr(AC, 8'h30, OK);
    rd(AC, 8'h2f, OK);
    chk(pll_enable_out, 1'b0, "loop enable");
    wr(AC, 8'h00, OK);
    wr(AM, 8'h44, OK);
    wr(AC, 8'h20, OK);
    chk(pll_enable_out, 1'b1, "loop enable");
    chk(filter_tracking_out, 1'b0, "filter mode");
    repeat (50) @(posedge clock_in);
    wr(AB, 8'h20, OK);
    chk(filter_tracking_out, 1'b1, "filter mode");
    rd(AB, 8'h20, OK);
    repeat (50) @(posedge clock_in);
    wr(AC, 8'h30, OK);
    rd(AC, 8'h3f, OK);
    wr(AC, 8'hb0, OK);
    rd(AC, 8'h3f, OK);
    wr(AC, 8'h20, OK);
    wr(AB, 8'h80, OK);
    wr(AC, 8'ha0, OK);
    wait_irq;
    rd(AB, 8'he0, OK);
    chk(filter_tracking_out, 1'b1, "filter mode");
    wr(AB, 8'h80, OK);
    rd(AB, 8'he0, OK);
    rd(AC, 8'hef, OK);
    chk(lock_irq_out, 1'b0, "lock irq");
    wr(AC, 8'hb0, OK);
    rd(AC, 8'hbf, OK);
    base_q = base_clock_out;
    repeat (4) @(posedge clock_in);
    chk(base_clock_out, {31'h0, ~base_q}, "base clock");
    vco_half <= 4'h3;
    wait_irq;
    rd(AB, 8'h80, OK);
    chk(filter_tracking_out, 1'b0, "filter mode");
    wr(AB, 8'h00, OK);
    rd(AC, 8'h3f, OK);
    chk(lock_irq_out, 1'b0, "lock irq");
    osc_enable_from_sysmod_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk(osc_run_out, 1'b0, "osc run");
    chk(pll_enable_out, 1'b0, "loop enable");
    report_and_stop;
  end
endmodule
`default_nettype wire

// File: testbench/pllcg_assertions.sv
// Purpose: Port-level checks of the clock generator control
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module pllcg_checker (
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic       osc_enable_from_sysmod_in,
  input wire logic       crystal_clock_in,
  input wire logic       osc_run_out,
  input wire logic       pll_reference_clock_out,
  input wire logic       final_reference_clock_out,
  input wire logic       vco_feedback_clock_out,
  input wire logic       pump_up_out,
  input wire logic       pump_down_out,
  input wire logic       pll_enable_out,
  input wire logic       filter_tracking_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic       s_axi_bvalid_out,
  input wire logic       s_axi_bready_in,
  input wire logic       s_axi_arvalid_in,
  input wire logic       s_axi_arready_out,
  input wire logic       s_axi_rvalid_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////
  // Clock path checks
  chk_osc_gate: assert property (
    !osc_enable_from_sysmod_in |=> !osc_run_out) else $error("Oscillator ran while disabled");
  chk_ref_copy: assert property (
    1'b1 |-> pll_reference_clock_out == $past(crystal_clock_in & osc_run_out))
    else $error("Reference clock is not the crystal copy");
  chk_ref_final: assert property (
    final_reference_clock_out == pll_reference_clock_out) else $error("Final reference differs");
  chk_fb_pulse: assert property (
    vco_feedback_clock_out |=> !vco_feedback_clock_out) else $error("Feedback pulse too long");
  chk_pump_clear: assert property (
    pump_up_out && pump_down_out |=> !pump_up_out && !pump_down_out)
    else $error("Pump pulses did not clear");
  chk_loop_gate: assert property (
    !osc_run_out [*2] |-> !pll_enable_out) else $error("Loop on without oscillator");
  chk_track_off: assert property (
    !pll_enable_out [*2] |-> !filter_tracking_out) else $error("Tracking while loop off");
  ////////////////////////////////////////////////////////////////
  // Bus answer checks
  chk_resp_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("Write response dropped early");
  chk_read_next: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("Read answer late");
endmodule
bind pllcg_top pllcg_checker i_pllcg_checker (.clock_in, .rst_n_in, .osc_enable_from_sysmod_in,
  .crystal_clock_in, .osc_run_out, .pll_reference_clock_out, .final_reference_clock_out,
  .vco_feedback_clock_out, .pump_up_out, .pump_down_out, .pll_enable_out, .filter_tracking_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out);
`default_nettype wire

// File: testbench/pllcg_far_model.sv
// Purpose: Far-side clock sources for the clock generator control
// Assumes: Clocks are levels stepped on the system clock
// Notes:   Crystal stands still while the oscillator is disabled
`timescale 1ns/1ps
`default_nettype none
module pllcg_far_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       osc_enable_in,
  input  wire logic [3:0] vco_half_in,
  output var  logic       crystal_clock_out,
  output var  logic       vco_clock_out
);
  localparam int XTAL_HALF = 8; // Crystal half period in system cycles
  logic [3:0] xcnt; // Crystal phase counter
  logic [3:0] vcnt; // VCO phase counter
  ////////////////////////////////////////////////////////////////
  // Crystal runs only when enabled, VCO runs free
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      xcnt <= 4'h0;
      vcnt <= 4'h0;
      crystal_clock_out <= 1'b0;
      vco_clock_out <= 1'b0;
    end
    else
    begin
      if (!osc_enable_in)
      begin
        xcnt <= 4'h0;
        crystal_clock_out <= 1'b0;
      end
      else if (xcnt == 4'(XTAL_HALF - 1))
      begin
        xcnt <= 4'h0;
        crystal_clock_out <= ~crystal_clock_out;
      end
      else
        xcnt <= xcnt + 4'h1;
      if (vcnt >= vco_half_in - 4'h1)
      begin
        vcnt <= 4'h0;
        vco_clock_out <= ~vco_clock_out;
      end
      else
        vcnt <= vcnt + 4'h1;
    end
  end
endmodule
`default_nettype wire
